// >>> include/osf_defs.vh
// constants for the optical module status and flag byte bank
// assumes inclusion by bare name from the design file
`ifndef OSF_DEFS_VH
`define OSF_DEFS_VH
`define OSF_ADDR_STATUS 8'h6E
`define OSF_ADDR_ALARM_LO 8'h70
`define OSF_ADDR_ALARM_HI 8'h71
`define OSF_ADDR_WARN_LO 8'h74
`define OSF_ADDR_WARN_HI 8'h75
`define OSF_ADDR_TEMP_MSB 8'h60
`define OSF_ADDR_TEMP_LSB 8'h61
`define OSF_BIT_SHUT_PIN 7
`define OSF_BIT_SOFT_SHUT 6
`define OSF_BIT_RATE_PIN 4
`define OSF_BIT_SOFT_RATE 3
`define OSF_BIT_FAULT 2
`define OSF_BIT_LOS 1
`define OSF_BIT_NOT_READY 0
`define OSF_SYNC_SHUT 0
`define OSF_SYNC_RATE 1
`define OSF_SYNC_FAULT 2
`define OSF_SYNC_LOS 3
`define OSF_SYNC_VALID 4
`define OSF_FLAG_TEMP_HI 7
`define OSF_FLAG_TEMP_LO 6
`define OSF_FLAG_VCC_HI 5
`define OSF_FLAG_VCC_LO 4
`define OSF_FLAG_BIAS_HI 3
`define OSF_FLAG_BIAS_LO 2
`define OSF_FLAG_TXP_HI 1
`define OSF_FLAG_TXP_LO 0
`define OSF_FLAG_RXP_HI 7
`define OSF_FLAG_RXP_LO 6
`define OSF_FLAGS_RESET 8'h00
`define OSF_SOFT_RESET 1'h0
`define OSF_NOT_READY_RESET 1'h1
`define OSF_STATUS_RESET 8'h01
`define OSF_RESP_MS 100
`define OSF_CLK_KHZ 125000
`define OSF_RESP_CYCLES (`OSF_RESP_MS * `OSF_CLK_KHZ)
`endif

// >>> design/osf_status_flags.v
// status/control byte and alarm/warning flag bytes of the diagnostic page
// assumes a serial-interface front end giving byte address, read and write strobes
// on the same clock; threshold compare results other than temperature come from the monitoring logic
//
// Contract
// - status bit shows shutdown pin level
// - soft shutdown bit 6 ORed with pin
// - soft shutdown is host readable and writable
// - status bit shows rate select pin level
// - soft rate bit 3 ORed with pin
// - effective rate picks high or low optimisation
// - status bit mirrors transmitter fault output
// - status bit mirrors signal lost output
// - not-ready bit low once data valid
// - soft commands take effect within 100 ms
// - byte 112 bits 7,6 temperature alarms
// - byte 112 bits 5,4 supply alarms
// - byte 112 bits 3,2 bias alarms
// - byte 112 bits 1,0 tx power alarms
// - byte 113 bits 7,6 rx power alarms
// - byte 116 bits 7,6 temperature warnings
// - byte 116 bits 5,4 supply warnings
// - byte 116 bits 3,2 bias warnings
// - byte 116 bits 1,0 tx power warnings
// - byte 117 bits 7,6 rx power warnings
// - status at 110, flags at 112,113,116,117
// - temperature is signed 1/256 degree units
// - temperature reading msb at 96, lsb next
`timescale 1ns/1ns
`include "osf_defs.vh"
module osf_status_flags #(
	parameter integer RESP_CYCLES = `OSF_RESP_CYCLES
) (
	input wire clock,
	input wire srst,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	input wire shutdown_pin,
	input wire rate_select_pin,
	input wire tx_fault_in,
	input wire receive_signal_lost_in,
	input wire data_valid,
	input wire signed [15:0] temperature,
	input wire signed [15:0] temp_high_alarm,
	input wire signed [15:0] temp_low_alarm,
	input wire signed [15:0] temp_high_warn,
	input wire signed [15:0] temp_low_warn,
	input wire [3:0] other_high_alarm,
	input wire [3:0] other_low_alarm,
	input wire [3:0] other_high_warn,
	input wire [3:0] other_low_warn,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	output reg tx_disable,
	output reg high_rate,
	output reg tx_fault_out,
	output reg receive_signal_lost_output
);
	// pins in sync order; the index macros keep the bundle and the views aligned
	localparam integer PIN_COUNT = 5;
	wire [PIN_COUNT-1:0] pin_raw;
	// two-stage synchroniser flops
	reg [PIN_COUNT-1:0] pin_meta;
	reg [PIN_COUNT-1:0] pin_sync;
	// named views of the synced pins
	wire sync_shut;
	wire sync_rate;
	wire sync_fault;
	wire sync_los;
	wire sync_valid;
	// host soft control bits, next values and applied copies
	reg soft_shut;
	reg soft_rate;
	reg next_soft_shut;
	reg next_soft_rate;
	reg soft_shut_eff;
	reg soft_rate_eff;
	// readiness as a flop, so the status byte never sees a sync edge twice
	reg not_ready;
	// registered flag bytes
	reg [7:0] alarm_lo;
	reg [7:0] alarm_hi;
	reg [7:0] warn_lo;
	reg [7:0] warn_hi;
	// flag bytes assembled from the live compares
	reg [7:0] next_alarm_lo;
	reg [7:0] next_alarm_hi;
	reg [7:0] next_warn_lo;
	reg [7:0] next_warn_hi;
	// read path
	reg [7:0] status_byte;
	reg [7:0] next_rdata;
	// decoded host strobe
	wire status_sel;
	wire status_wr;
	// temperature compare results
	wire temp_ha;
	wire temp_la;
	wire temp_hw;
	wire temp_lw;
	genvar gi;

	// bundle the async pins; order must match the sync index macros
	assign pin_raw[`OSF_SYNC_SHUT] = shutdown_pin;
	assign pin_raw[`OSF_SYNC_RATE] = rate_select_pin;
	assign pin_raw[`OSF_SYNC_FAULT] = tx_fault_in;
	assign pin_raw[`OSF_SYNC_LOS] = receive_signal_lost_in;
	assign pin_raw[`OSF_SYNC_VALID] = data_valid;

	// two flops per pin; only the second stage is read, so a metastable
	// first stage never fans out into the decode
	generate
		for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_sync
			always @(posedge clock) begin
				if (srst) begin
					pin_meta[gi] <= 1'h0;
					pin_sync[gi] <= 1'h0;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	// named views of the second stage
	assign sync_shut = pin_sync[`OSF_SYNC_SHUT];
	assign sync_rate = pin_sync[`OSF_SYNC_RATE];
	assign sync_fault = pin_sync[`OSF_SYNC_FAULT];
	assign sync_los = pin_sync[`OSF_SYNC_LOS];
	assign sync_valid = pin_sync[`OSF_SYNC_VALID];

	// signed compare in 1/256 degree units; equal to a threshold is no flag
	assign temp_ha = temperature > temp_high_alarm;
	assign temp_la = temperature < temp_low_alarm;
	assign temp_hw = temperature > temp_high_warn;
	assign temp_lw = temperature < temp_low_warn;

	// only byte 110 takes writes; writes elsewhere fall away
	assign status_sel = reg_addr == `OSF_ADDR_STATUS;
	assign status_wr = reg_wr & status_sel;

	// next soft bits; only bits 6 and 3 are stored, the rest is read-only
	always @* begin
		next_soft_shut = soft_shut;
		next_soft_rate = soft_rate;
		if (status_wr) begin
			next_soft_shut = reg_wdata[`OSF_BIT_SOFT_SHUT];
			next_soft_rate = reg_wdata[`OSF_BIT_SOFT_RATE];
		end
	end

	// soft control registers, cleared by reset
	always @(posedge clock) begin
		if (srst) begin
			soft_shut <= `OSF_SOFT_RESET;
			soft_rate <= `OSF_SOFT_RESET;
		end else begin
			soft_shut <= next_soft_shut;
			soft_rate <= next_soft_rate;
		end
	end

	// soft bits apply one cycle later; the response limit leaves a wide margin
	always @(posedge clock) begin
		if (srst) begin
			soft_shut_eff <= `OSF_SOFT_RESET;
			soft_rate_eff <= `OSF_SOFT_RESET;
		end else begin
			soft_shut_eff <= soft_shut;
			soft_rate_eff <= soft_rate;
		end
	end

	// transmitter disable; either source alone forces it off
	always @(posedge clock) begin
		if (srst) begin
			tx_disable <= 1'h0;
		end else begin
			tx_disable <= sync_shut | soft_shut_eff;
		end
	end

	// rate choice; high selects the faster optimisation pair
	always @(posedge clock) begin
		if (srst) begin
			high_rate <= 1'h0;
		end else begin
			high_rate <= sync_rate | soft_rate_eff;
		end
	end

	// fault copy, same latency as the status bit
	always @(posedge clock) begin
		if (srst) begin
			tx_fault_out <= 1'h0;
		end else begin
			tx_fault_out <= sync_fault;
		end
	end

	// signal lost copy, same latency as the status bit
	always @(posedge clock) begin
		if (srst) begin
			receive_signal_lost_output <= 1'h0;
		end else begin
			receive_signal_lost_output <= sync_los;
		end
	end

	// readiness is active low; not ready until data valid has been synced
	always @(posedge clock) begin
		if (srst) begin
			not_ready <= `OSF_NOT_READY_RESET;
		end else begin
			not_ready <= ~sync_valid;
		end
	end

	// flag assembly; reserved bits of 113 and 117 stay at the zero default
	always @* begin
		next_alarm_lo = `OSF_FLAGS_RESET;
		next_alarm_hi = `OSF_FLAGS_RESET;
		next_warn_lo = `OSF_FLAGS_RESET;
		next_warn_hi = `OSF_FLAGS_RESET;
		next_alarm_lo[`OSF_FLAG_TEMP_HI] = temp_ha;
		next_alarm_lo[`OSF_FLAG_TEMP_LO] = temp_la;
		next_alarm_lo[`OSF_FLAG_VCC_HI] = other_high_alarm[0];
		next_alarm_lo[`OSF_FLAG_VCC_LO] = other_low_alarm[0];
		next_alarm_lo[`OSF_FLAG_BIAS_HI] = other_high_alarm[1];
		next_alarm_lo[`OSF_FLAG_BIAS_LO] = other_low_alarm[1];
		next_alarm_lo[`OSF_FLAG_TXP_HI] = other_high_alarm[2];
		next_alarm_lo[`OSF_FLAG_TXP_LO] = other_low_alarm[2];
		next_alarm_hi[`OSF_FLAG_RXP_HI] = other_high_alarm[3];
		next_alarm_hi[`OSF_FLAG_RXP_LO] = other_low_alarm[3];
		next_warn_lo[`OSF_FLAG_TEMP_HI] = temp_hw;
		next_warn_lo[`OSF_FLAG_TEMP_LO] = temp_lw;
		next_warn_lo[`OSF_FLAG_VCC_HI] = other_high_warn[0];
		next_warn_lo[`OSF_FLAG_VCC_LO] = other_low_warn[0];
		next_warn_lo[`OSF_FLAG_BIAS_HI] = other_high_warn[1];
		next_warn_lo[`OSF_FLAG_BIAS_LO] = other_low_warn[1];
		next_warn_lo[`OSF_FLAG_TXP_HI] = other_high_warn[2];
		next_warn_lo[`OSF_FLAG_TXP_LO] = other_low_warn[2];
		next_warn_hi[`OSF_FLAG_RXP_HI] = other_high_warn[3];
		next_warn_hi[`OSF_FLAG_RXP_LO] = other_low_warn[3];
	end

	// flags follow the live compares, one cycle behind; they are not sticky
	always @(posedge clock) begin
		if (srst) begin
			alarm_lo <= `OSF_FLAGS_RESET;
			alarm_hi <= `OSF_FLAGS_RESET;
			warn_lo <= `OSF_FLAGS_RESET;
			warn_hi <= `OSF_FLAGS_RESET;
		end else begin
			alarm_lo <= next_alarm_lo;
			alarm_hi <= next_alarm_hi;
			warn_lo <= next_warn_lo;
			warn_hi <= next_warn_hi;
		end
	end

	// status byte assembly, reserved bit 5 reads zero
	always @* begin
		status_byte = 8'h00;
		status_byte[`OSF_BIT_SHUT_PIN] = sync_shut;
		status_byte[`OSF_BIT_SOFT_SHUT] = soft_shut;
		status_byte[`OSF_BIT_RATE_PIN] = sync_rate;
		status_byte[`OSF_BIT_SOFT_RATE] = soft_rate;
		status_byte[`OSF_BIT_FAULT] = sync_fault;
		status_byte[`OSF_BIT_LOS] = sync_los;
		status_byte[`OSF_BIT_NOT_READY] = not_ready;
	end

	// read decode; unmapped bytes read zero
	always @* begin
		case (reg_addr)
			`OSF_ADDR_STATUS: next_rdata = status_byte;
			`OSF_ADDR_ALARM_LO: next_rdata = alarm_lo;
			`OSF_ADDR_ALARM_HI: next_rdata = alarm_hi;
			`OSF_ADDR_WARN_LO: next_rdata = warn_lo;
			`OSF_ADDR_WARN_HI: next_rdata = warn_hi;
			`OSF_ADDR_TEMP_MSB: next_rdata = temperature[15:8];
			`OSF_ADDR_TEMP_LSB: next_rdata = temperature[7:0];
			default: next_rdata = 8'h00;
		endcase
	end

	// read answer one cycle after the strobe; data holds until the next read
	always @(posedge clock) begin
		if (srst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'h0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end
endmodule

// >>> verif/osf_status_flags_chk.sv
// port checker for the status flag bank
// bound to the top module, sees its ports only
`timescale 1ns/1ns
module osf_chk(
	input wire clock,
	input wire srst,
	input wire [7:0] reg_addr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire reg_rvalid,
	input wire shutdown_pin,
	input wire rate_select_pin,
	input wire tx_disable,
	input wire high_rate
);
	reg [1:0] age;
	// edges since reset; pins need three
	always @(posedge clock) begin
		age <= srst ? 2'h0 : age + {1'h0, age != 2'h3};
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (srst);
	sequence rd_at(a);
		reg_rd && reg_addr == a;
	endsequence
	read_answer_a: assert property (!$past(srst) |-> reg_rvalid == $past(reg_rd)) else $error("bad rvalid");
	rdata_hold_a: assert property (!$past(srst) && !reg_rvalid |-> $stable(reg_rdata)) else $error("bad hold");
	rsv_alarm_a: assert property (rd_at(8'h71) |=> reg_rdata[5:0] == 6'h00) else $error("bad 113");
	rsv_warn_a: assert property (rd_at(8'h75) |=> reg_rdata[5:0] == 6'h00) else $error("bad 117");
	rsv_status_a: assert property (rd_at(8'h6E) |=> !reg_rdata[5]) else $error("bad 110");
	unmapped_read_a: assert property (rd_at(8'h6F) |=> reg_rdata == 8'h00) else $error("bad 111");
	shut_pin_a: assert property (age == 2'h3 && $past(shutdown_pin, 3) |-> tx_disable) else $error("bad txd");
	rate_pin_a: assert property (age == 2'h3 && $past(rate_select_pin, 3) |-> high_rate) else $error("bad rate");
endmodule
bind osf_status_flags osf_chk u_chk(.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .shutdown_pin(shutdown_pin),
	.rate_select_pin(rate_select_pin), .tx_disable(tx_disable), .high_rate(high_rate));

// >>> verif/osf_host.sv
// host model: register strobes
// assumes the bank's clock
`timescale 1ns/1ns
module osf_host(
	input wire clock,
	output reg [7:0] reg_addr = 8'h00,
	output reg reg_wr = 1'h0,
	output reg [7:0] reg_wdata = 8'h00,
	output reg reg_rd = 1'h0
);
	// strobe held over one taking edge
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clock) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
		@(posedge clock) #1 reg_wr = 1'h0;
	endtask
	task rd(input [7:0] a);
		@(posedge clock) #1 {reg_addr, reg_rd} = {a, 1'h1};
		@(posedge clock) #1 reg_rd = 1'h0;
	endtask
endmodule

// >>> verif/osf_status_flags_tb.sv
// bench for the status flag bank
// osf_host drives strobes, bench drives pins
`timescale 1ns/1ns
module osf_status_flags_tb;
	reg clock = 0, srst = 1, sp = 0, rp = 0, fi = 0, li = 0, dv = 0;
	reg [15:0] tmp = 0;
	reg [3:0] oh = 0, ol = 0;
	wire [7:0] a, wd, rdata;
	wire w, r, rv, txd, hr, fo, lo;
	integer mismatches = 0, check_count = 0, cyc = 0;
	osf_host u_host(.clock(clock), .reg_addr(a), .reg_wr(w), .reg_wdata(wd), .reg_rd(r));
	osf_status_flags #(.RESP_CYCLES(4)) u_dut(.clock(clock), .srst(srst), .reg_addr(a), .reg_wr(w),
		.reg_wdata(wd), .reg_rd(r), .shutdown_pin(sp), .rate_select_pin(rp), .tx_fault_in(fi),
		.receive_signal_lost_in(li), .data_valid(dv), .temperature(tmp), .temp_high_alarm(16'h1000),
		.temp_low_alarm(16'hF000), .temp_high_warn(16'h0800), .temp_low_warn(16'hF800),
		.other_high_alarm(oh), .other_low_alarm(ol), .other_high_warn(ol), .other_low_warn(oh),
		.reg_rdata(rdata), .reg_rvalid(rv), .tx_disable(txd), .high_rate(hr), .tx_fault_out(fo),
		.receive_signal_lost_output(lo));
	initial forever #4 clock = ~clock;
	// hang guard
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			mismatches = mismatches + 1;
			summarize;
		end
	end
	task chk(input [8:0] got, input [8:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rd(input [7:0] ad, input [7:0] exp);
		u_host.rd(ad);
		chk({rv, rdata}, {1'h1, exp});
	endtask
	// bounded settle, past the 3-cycle response
	task w4;
		repeat (4) @(posedge clock);
		#1;
	endtask
	task t_soft;
		rd(8'h6E, 8'h01);
		u_host.wr(8'h6E, 8'hFF);
		u_host.wr(8'h70, 8'hFF);
		rd(8'h6E, 8'h49);
		rd(8'h70, 8'h00);
		chk({txd, hr}, 2'h3);
		u_host.wr(8'h6E, 8'h08);
		w4;
		chk({txd, hr}, 2'h1);
		rd(8'h6F, 8'h00);
		u_host.wr(8'h6E, 8'h00);
		$display("t_soft done");
	endtask
	task t_pins;
		{sp, rp, fi, li, dv} = 5'h1F;
		w4;
		chk({txd, hr, fo, lo}, 4'hF);
		rd(8'h6E, 8'h96);
		{sp, rp, fi, li} = 4'h0;
		w4;
		chk({txd, hr, fo, lo}, 4'h0);
		$display("t_pins done");
	endtask
	task t_flags;
		tmp = 16'h0C00;
		{oh, ol} = 8'h5A;
		rd(8'h70, 8'h26);
		rd(8'h71, 8'h40);
		rd(8'h74, 8'h99);
		rd(8'h75, 8'h80);
		tmp = 16'hE012;
		{oh, ol} = 8'h00;
		rd(8'h70, 8'h40);
		rd(8'h74, 8'h40);
		rd(8'h60, 8'hE0);
		rd(8'h61, 8'h12);
		$display("t_flags done");
	endtask
	// mid-run reset clears soft bits; readiness waits for the pin again
	task t_reset;
		u_host.wr(8'h6E, 8'h48);
		@(posedge clock) #1 srst = 1;
		repeat (2) @(posedge clock);
		#1 srst = 0;
		chk({txd, hr, fo, lo}, 4'h0);
		rd(8'h6E, 8'h01);
		$display("t_reset done");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		#1 srst = 0;
		t_soft;
		t_pins;
		t_flags;
		t_reset;
		summarize;
	end
endmodule
